/* File: rtl/slfl_loader.sv */
// Function
// - start instruction opens new frame
// - start instruction clears grayscale counter
// - first strobe latches 16-bit command
// - next strobes store scan lines in order
// - scan latch count equals divisor N
// - mode field plus one gives N
// - serial input sampled on clock rise
`timescale 1ns/1ps
`include "slfl_map.svh"

module slfl_loader #(
   parameter int SCAN_BITS = `SLFL_SCAN_BITS,
   parameter int MAX_SCANS = `SLFL_MAX_SCANS,
   parameter int GRAY_W = `SLFL_GRAY_W
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_serial_in,
   input wire logic i_shift_clock,
   input wire logic i_latch_strobe,
   input wire logic i_grayscale_clock,
   input wire logic [3:0] i_rd_line,
   output logic o_serial_out,
   output logic o_frame_start,
   output logic o_frame_show,
   output logic [`SLFL_CMD_W-1:0] o_command,
   output logic o_scan_wr,
   output logic [3:0] o_scan_line,
   output logic [SCAN_BITS-1:0] o_rd_data,
   output logic [GRAY_W-1:0] o_gray_count,
   output logic o_error
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detection

   logic [1:0] din_sync_reg;
   logic [2:0] sck_sync_reg;
   logic [2:0] lat_sync_reg;
   logic [2:0] gck_sync_reg;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         din_sync_reg <= 2'h0;
         sck_sync_reg <= 3'h0;
         lat_sync_reg <= 3'h0;
         gck_sync_reg <= 3'h0;
      end else begin
         din_sync_reg <= {din_sync_reg[0], i_serial_in};
         sck_sync_reg <= {sck_sync_reg[1:0], i_shift_clock};
         lat_sync_reg <= {lat_sync_reg[1:0], i_latch_strobe};
         gck_sync_reg <= {gck_sync_reg[1:0], i_grayscale_clock};
      end
   end

   wire din = din_sync_reg[1];
   wire lat_high = lat_sync_reg[1];
   wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
   wire lat_rise = lat_sync_reg[1] & ~lat_sync_reg[2];
   wire lat_fall = ~lat_sync_reg[1] & lat_sync_reg[2];
   wire gck_rise = gck_sync_reg[1] & ~gck_sync_reg[2];

   ////////////////////////////////////////////////////////////////////////////
   // serial shift path

   logic [SCAN_BITS-1:0] shift_reg;
   // clocks under a high strobe belong to an instruction, not to data
   wire shift_en = sck_rise & ~lat_high;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         shift_reg <= '0;
      end else if (shift_en) begin
         shift_reg <= {shift_reg[SCAN_BITS-2:0], din};
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_serial_out <= 1'b0;
      end else begin
         o_serial_out <= shift_reg[SCAN_BITS-1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // strobe classification

   logic [2:0] pulse_cnt_reg;
   logic [2:0] pulse_cnt_next;

   always_comb begin
      pulse_cnt_next = pulse_cnt_reg;
      if (lat_rise) begin
         pulse_cnt_next = 3'h0;
      end else if (sck_rise && lat_high && pulse_cnt_reg != 3'h7) begin
         pulse_cnt_next = pulse_cnt_reg + 3'h1;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         pulse_cnt_reg <= 3'h0;
      end else begin
         pulse_cnt_reg <= pulse_cnt_next;
      end
   end

   wire start_det = lat_fall & (pulse_cnt_reg == `SLFL_START_PULSES);
   // a strobe with no clocks under it is a data latch
   wire latch_det = lat_fall & (pulse_cnt_reg == 3'h0);
   // any other pulse count is a malformed instruction
   wire bad_det = lat_fall & ~start_det & ~latch_det;

   ////////////////////////////////////////////////////////////////////////////
   // frame sequencer

   slfl_pkg::slfl_state_t state_reg;
   slfl_pkg::slfl_state_t state_next;
   logic [3:0] scan_idx_reg;
   logic [3:0] scan_idx_next;

   wire [3:0] mode_field = o_command[`SLFL_MODE_MSB:`SLFL_MODE_LSB];
   wire [4:0] scan_total = {1'b0, mode_field} + 5'h01;
   // last scan at N minus one
   wire last_scan = ({1'b0, scan_idx_reg} == scan_total - 5'h01);
   wire cmd_latch = latch_det & (state_reg == slfl_pkg::SLFL_CMD);
   wire scan_latch = latch_det & (state_reg == slfl_pkg::SLFL_SCAN);

   always_comb begin
      state_next = state_reg;
      scan_idx_next = scan_idx_reg;
      unique case (state_reg)
         slfl_pkg::SLFL_IDLE, slfl_pkg::SLFL_DONE: begin
         end
         slfl_pkg::SLFL_CMD: begin
            if (latch_det) begin
               state_next = slfl_pkg::SLFL_SCAN;
            end
         end
         slfl_pkg::SLFL_SCAN: begin
            if (latch_det) begin
               scan_idx_next = scan_idx_reg + 4'h1;
               if (last_scan) begin
                  state_next = slfl_pkg::SLFL_DONE;
               end
            end
         end
      endcase
      if (start_det) begin
         state_next = slfl_pkg::SLFL_CMD;
         scan_idx_next = 4'h0;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= slfl_pkg::SLFL_IDLE;
         scan_idx_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         scan_idx_reg <= scan_idx_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command word and status pulses

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_command <= `SLFL_CMD_RESET;
      end else if (cmd_latch) begin
         o_command <= shift_reg[`SLFL_CMD_W-1:0];
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_frame_start <= 1'b0;
         o_frame_show <= 1'b0;
         o_scan_wr <= 1'b0;
         o_scan_line <= 4'h0;
         o_error <= 1'b0;
      end else begin
         o_frame_start <= start_det;
         // start after full frame shows it
         o_frame_show <= start_det & (state_reg == slfl_pkg::SLFL_DONE);
         o_scan_wr <= scan_latch;
         o_scan_line <= scan_latch ? scan_idx_reg : o_scan_line;
         o_error <= bad_det;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // scan line store

   logic [SCAN_BITS-1:0] scan_mem [MAX_SCANS];

   always_ff @(posedge i_ref_clk) begin
      if (scan_latch) begin
         scan_mem[scan_idx_reg] <= shift_reg;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= '0;
      end else begin
         o_rd_data <= scan_mem[i_rd_line];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // grayscale counter

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_gray_count <= '0;
      end else if (start_det) begin
         o_gray_count <= '0;
      end else if (gck_rise) begin
         o_gray_count <= o_gray_count + GRAY_W'(1);
      end
   end

endmodule : slfl_loader

/* File: rtl/slfl_map.svh */
`ifndef SLFL_MAP_SVH
`define SLFL_MAP_SVH

// clock pulses that make a start instruction while the strobe is high
`define SLFL_START_PULSES 3'd5
// command word layout
`define SLFL_CMD_W 16
`define SLFL_CMD_RESET 16'h0080
`define SLFL_MODE_MSB 13
`define SLFL_MODE_LSB 10
// per-scan data: 16 outputs of 16 bits
`define SLFL_SCAN_BITS 256
`define SLFL_MAX_SCANS 16
`define SLFL_GRAY_W 16

`endif

/* File: rtl/slfl_pkg.sv */
package slfl_pkg;

   typedef enum logic [1:0] {
      SLFL_IDLE,
      SLFL_CMD,
      SLFL_SCAN,
      SLFL_DONE
   } slfl_state_t;

endpackage : slfl_pkg

/* File: tb/slfl_loader_sva.sv */
`timescale 1ns/1ps
module slfl_loader_sva (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_shift_clock,
   input wire logic o_serial_out,
   input wire logic o_frame_start,
   input wire logic [15:0] o_command,
   input wire logic o_scan_wr,
   input wire logic [3:0] o_scan_line,
   input wire logic [15:0] o_gray_count,
   input wire logic o_error
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   a_gray_cleared:
      assert property (o_frame_start |-> o_gray_count == 16'h0000) else $error("gray not cleared");
   a_start_pulse:
      assert property (o_frame_start |=> !o_frame_start) else $error("start pulse too long");
   a_cmd_steady:
      assert property (o_scan_wr |-> $stable(o_command)) else $error("command moved on scan");
   a_line_step:
      assert property (o_scan_wr && o_scan_line != 4'h0 |-> o_scan_line == $past(o_scan_line) + 4'h1)
         else $error("scan line skipped");
   a_line_bound:
      assert property (o_scan_wr |-> o_scan_line <= o_command[13:10]) else $error("too many scans");
   a_wr_pulse:
      assert property (o_scan_wr |=> !o_scan_wr) else $error("scan pulse too long");
   a_chain_clock:
      assert property ($changed(o_serial_out) |-> $past(i_shift_clock, 2) || $past(i_shift_clock, 4))
         else $error("chain moved without clock");
   a_err_no_start:
      assert property (o_error |-> !o_frame_start) else $error("bad start opened frame");
endmodule : slfl_loader_sva
bind slfl_loader slfl_loader_sva slfl_loader_sva_i (.*);

/* File: tb/slfl_ctl_model.sv */
`timescale 1ns/1ps
module slfl_ctl_model (
   input wire logic i_ref_clk,
   output logic o_serial_in,
   output logic o_shift_clock,
   output logic o_latch_strobe
);
   initial begin
      o_serial_in = 1'b0;
      o_shift_clock = 1'b0;
      o_latch_strobe = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask : tick
   task automatic shift(input logic [255:0] v, input int n);
      for (int k = n - 1; k >= 0; k--) begin
         o_serial_in = v[k];
         tick(2);
         o_shift_clock = 1'b1;
         tick(4);
         o_shift_clock = 1'b0;
         tick(2);
      end
      o_serial_in = ~o_serial_in;
   endtask : shift
   task automatic start(input int pulses);
      o_latch_strobe = 1'b1;
      tick(2);
      shift('0, pulses);
      o_latch_strobe = 1'b0;
      tick(8);
   endtask : start
   task automatic latch();
      o_latch_strobe = 1'b1;
      tick(6);
      o_latch_strobe = 1'b0;
      tick(8);
   endtask : latch
endmodule : slfl_ctl_model

/* File: tb/slfl_loader_tb_top.sv */
`timescale 1ns/1ps
module slfl_loader_tb_top;
   logic i_ref_clk, i_rst, i_serial_in, i_shift_clock, i_latch_strobe, i_grayscale_clock;
   logic o_serial_out, o_frame_start, o_frame_show, o_scan_wr, o_error;
   logic [3:0] i_rd_line, o_scan_line;
   logic [15:0] o_command, o_gray_count;
   logic [255:0] o_rd_data;
   int n_fail = 0, n_tests = 0, n_start = 0, n_show = 0, n_wr = 0, n_err = 0;
   slfl_loader slfl_loader_i (.*);
   slfl_ctl_model slfl_ctl_model_i (.i_ref_clk(i_ref_clk), .o_serial_in(i_serial_in),
      .o_shift_clock(i_shift_clock), .o_latch_strobe(i_latch_strobe));
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   // pulses are counted mid-cycle, away from the edge that launches them
   always @(negedge i_ref_clk) begin
      n_start += (o_frame_start === 1'b1);
      n_show += (o_frame_show === 1'b1);
      n_wr += (o_scan_wr === 1'b1);
      n_err += (o_error === 1'b1);
   end
   always @(posedge i_ref_clk) begin
      #1 i_grayscale_clock = ~i_grayscale_clock;
   end
   task chk(input logic [255:0] got, input logic [255:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task bad_start();
      int e0;
      e0 = n_err;
      slfl_ctl_model_i.start(4);
      slfl_ctl_model_i.start(6);
      slfl_ctl_model_i.shift(256'h3c00, 16);
      slfl_ctl_model_i.latch();
      chk(n_err - e0, 2);
      chk(n_start, 0);
      chk(o_command, 16'h0080);
   endtask : bad_start
   task frame(input logic [3:0] mode);
      int s0, w0, h0;
      logic [15:0] cmd;
      logic [255:0] pat;
      cmd = 16'h0080 | {2'b00, mode, 10'h000};
      pat = {16{12'h5a3, mode}};
      slfl_ctl_model_i.shift(cmd, 16);
      slfl_ctl_model_i.latch();
      chk(o_command, cmd);
      slfl_ctl_model_i.shift(pat, 256);
      chk(o_serial_out, pat[255]);
      w0 = n_wr;
      for (int k = 0; k < mode + 2; k++) slfl_ctl_model_i.latch();
      chk(n_wr - w0, mode + 1);
      chk(o_scan_line, mode);
      i_rd_line = 4'h0;
      slfl_ctl_model_i.tick(2);
      chk(o_rd_data, pat);
      i_rd_line = mode;
      slfl_ctl_model_i.tick(2);
      chk(o_rd_data, pat);
      s0 = n_start;
      h0 = n_show;
      slfl_ctl_model_i.start(5);
      chk(n_start - s0, 1);
      chk(n_show - h0, 1);
      chk(o_gray_count < 16'h0008, 1'b1);
   endtask : frame
   task conclude();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   initial begin
      i_rst = 1'b1;
      i_rd_line = 4'h0;
      i_grayscale_clock = 1'b0;
      repeat (20) @(posedge i_ref_clk);
      #1 i_rst = 1'b0;
      slfl_ctl_model_i.tick(3);
      bad_start();
      slfl_ctl_model_i.start(5);
      for (int m = 0; m < 16; m++) frame(m[3:0]);
      conclude();
   end
   initial begin
      #600000;
      n_fail++;
      conclude();
   end
endmodule : slfl_loader_tb_top
